/* File: hw/pin_fall_detect.sv */
// pin synchroniser with falling edge pulse
`timescale 1ns/1ns
module pin_fall_detect
   import tmr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic pin,
   output logic fall
);
   edge_state_type st_reg;
   edge_state_type st_next;

   // first stage feeds only the second stage
   always_comb
   begin
      st_next = st_reg;
      st_next.sync_a = pin;
      st_next.sync_b = st_reg.sync_a;
      st_next.last = st_reg.sync_b;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '{sync_a: 1'b1, sync_b: 1'b1, last: 1'b1};
      else if (ce)
         st_reg <= st_next;
   end

   // pulse while high was followed by low in the synchronised copy
   assign fall = st_reg.last & ~st_reg.sync_b;
endmodule : pin_fall_detect

/* File: hw/timer_capture_reload.sv */
// sixteen-bit timer/counter with auto-reload and capture, APB register slave
// Contract
// - In timer mode the count advances once every 2 system clocks.
// - In counter mode the count advances on each falling edge of the count pin.
// - In reload mode overflow reloads the count, and so does an enabled trigger fall.
// - In capture mode an enabled trigger fall copies the count into the capture pair.
// - With either baud-source bit set, mode select is ignored and overflow reloads.
// - The reload/capture pair is readable and writable as two bytes at CAh and CBh.
// - The live count is readable and writable as two bytes at CCh and CDh, reset to 00h.
// - Overflow sets the overflow flag unless a baud-source bit is set; software clears it.
// - A trigger fall causing capture or reload sets the trigger flag; software clears it.
// - Trigger falls act only with the trigger enabled and both baud-source bits low.
`timescale 1ns/1ns
module timer_capture_reload
   import tmr_pkg::*;
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic COUNT_INPUT_PIN,
   input wire logic TRIGGER_INPUT_PIN,
   output logic OVERFLOW_PULSE
);
   typedef struct packed {
      logic [7:0] reload_low;
      logic [7:0] reload_high;
      logic [15:0] count;
      logic overflow_flag;
      logic trigger_event_flag;
      logic rx_baud_source;
      logic tx_baud_source;
      logic trigger_pin_enable;
      logic run_control;
      logic count_source_select;
      logic capture_reload_select;
      logic [31:0] rdata;
      logic slverr;
      logic ovf_pulse;
   } tmr_state_type;

   tmr_state_type st_reg;
   tmr_state_type st_next;
   logic rst_meta_reg;
   logic rst_sync_reg;
   logic count_fall;
   logic trig_fall;
   logic pre_tick;

   // reset released through two flops so all state leaves reset on the same edge
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   pin_fall_detect count_edge (
      .clk(CLK),
      .rst_n(rst_sync_reg),
      .ce(CE),
      .pin(COUNT_INPUT_PIN),
      .fall(count_fall)
   );

   pin_fall_detect trigger_edge (
      .clk(CLK),
      .rst_n(rst_sync_reg),
      .ce(CE),
      .pin(TRIGGER_INPUT_PIN),
      .fall(trig_fall)
   );

   timer_prescale prescale (
      .clk(CLK),
      .rst_n(rst_sync_reg),
      .ce(CE),
      .run(st_reg.run_control & ~st_reg.count_source_select),
      .tick(pre_tick)
   );

   logic access;
   logic wr;
   logic [7:0] word_idx;
   logic addr_ok;
   logic baud_mode;
   logic inc;
   logic overflow;
   logic trig_act;
   logic [7:0] wbyte;
   logic [7:0] ctrl_read;

   // decode: word index is the byte address divided by four
   assign access = PSEL & PENABLE;
   assign wr = access & PWRITE & PSTRB[0];
   assign word_idx = PADDR[9:2];
   assign addr_ok = (PADDR[31:10] == 22'h0) && (PADDR[1:0] == 2'h0) &&
      (word_idx == IDX_RELOAD_LOW || word_idx == IDX_RELOAD_HIGH ||
       word_idx == IDX_COUNT_LOW || word_idx == IDX_COUNT_HIGH ||
       word_idx == IDX_CONTROL);
   assign wbyte = PWDATA[7:0];
   assign baud_mode = st_reg.rx_baud_source | st_reg.tx_baud_source;

   // count enable from the selected source, gated by run
   assign inc = st_reg.run_control &
      (st_reg.count_source_select ? count_fall : pre_tick);
   assign overflow = inc & (st_reg.count == 16'hffff);
   assign trig_act = trig_fall & st_reg.trigger_pin_enable & ~baud_mode;

   assign ctrl_read = {st_reg.overflow_flag, st_reg.trigger_event_flag,
      st_reg.rx_baud_source, st_reg.tx_baud_source, st_reg.trigger_pin_enable,
      st_reg.run_control, st_reg.count_source_select, st_reg.capture_reload_select};

   // software writes first, then the timer engine; hardware flag sets override clears
   always_comb
   begin
      st_next = st_reg;
      st_next.ovf_pulse = overflow;
      // software writes to registers
      if (wr && addr_ok)
      begin
         case (word_idx)
            IDX_RELOAD_LOW: st_next.reload_low = wbyte;
            IDX_RELOAD_HIGH: st_next.reload_high = wbyte;
            IDX_COUNT_LOW: st_next.count[7:0] = wbyte;
            IDX_COUNT_HIGH: st_next.count[15:8] = wbyte;
            IDX_CONTROL:
            begin
               st_next.overflow_flag = wbyte[BIT_OVERFLOW];
               st_next.trigger_event_flag = wbyte[BIT_TRIGGER_EVENT];
               st_next.rx_baud_source = wbyte[BIT_RX_BAUD];
               st_next.tx_baud_source = wbyte[BIT_TX_BAUD];
               st_next.trigger_pin_enable = wbyte[BIT_TRIGGER_ENABLE];
               st_next.run_control = wbyte[BIT_RUN];
               st_next.count_source_select = wbyte[BIT_COUNT_SOURCE];
               st_next.capture_reload_select = wbyte[BIT_CAPTURE_RELOAD];
            end
            default: st_next.count = st_reg.count;
         endcase
      end
      // counting; a count written this cycle is overridden by the engine
      if (inc)
         st_next.count = st_reg.count + 16'h0001;
      // overflow reload in reload mode, or always in baud mode
      if (overflow && (baud_mode || !st_reg.capture_reload_select))
         st_next.count = {st_reg.reload_high, st_reg.reload_low};
      // trigger falls
      if (trig_act)
      begin
         st_next.trigger_event_flag = 1'b1;
         if (st_reg.capture_reload_select)
         begin
            // capture the count as it stood before this cycle's increment
            st_next.reload_low = st_reg.count[7:0];
            st_next.reload_high = st_reg.count[15:8];
         end
         else
            st_next.count = {st_reg.reload_high, st_reg.reload_low};
      end
      if (overflow && !baud_mode)
         st_next.overflow_flag = 1'b1;
      // read data and error answer are captured in the setup cycle and dropped at the
      // access edge, so the bus shows zero in every cycle outside an access
      st_next.rdata = 32'h0;
      st_next.slverr = 1'b0;
      if (PSEL && !PENABLE)
      begin
         st_next.slverr = ~addr_ok;
         if (!PWRITE)
         begin
            case (word_idx)
               IDX_RELOAD_LOW: st_next.rdata = {24'h0, st_reg.reload_low};
               IDX_RELOAD_HIGH: st_next.rdata = {24'h0, st_reg.reload_high};
               IDX_COUNT_LOW: st_next.rdata = {24'h0, st_reg.count[7:0]};
               IDX_COUNT_HIGH: st_next.rdata = {24'h0, st_reg.count[15:8]};
               IDX_CONTROL: st_next.rdata = {24'h0, ctrl_read};
               default: st_next.rdata = 32'h0;
            endcase
            if (!addr_ok)
               st_next.rdata = 32'h0;
         end
      end
   end

   // timer and bus state in one register, frozen while the clock enable is low
   always_ff @(posedge CLK or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
      begin
         st_reg <= '0;
         st_reg.reload_low <= RESET_BYTE;
         st_reg.reload_high <= RESET_BYTE;
         st_reg.count <= {RESET_BYTE, RESET_BYTE};
      end
      else if (CE)
         st_reg <= st_next;
   end

   // no wait states: data is prepared in setup and presented in access
   assign PREADY = 1'b1;
   assign PRDATA = st_reg.rdata;
   assign PSLVERR = st_reg.slverr & access;
   assign OVERFLOW_PULSE = st_reg.ovf_pulse;
endmodule : timer_capture_reload

/* File: hw/timer_prescale.sv */
// divides the system clock for timer mode counting
`timescale 1ns/1ns
module timer_prescale
   import tmr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic run,
   output logic tick
);
   typedef struct packed {
      logic [1:0] cnt;
   } pre_state_type;
   pre_state_type st_reg;
   pre_state_type st_next;

   // counter held at zero while stopped so the first tick lands two clocks after start
   always_comb
   begin
      st_next = st_reg;
      if (!run)
         st_next.cnt = 2'h0;
      else if (st_reg.cnt == TIMER_DIVIDE - 2'h1)
         st_next.cnt = 2'h0;
      else
         st_next.cnt = st_reg.cnt + 2'h1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '{cnt: 2'h0};
      else if (ce)
         st_reg <= st_next;
   end

   assign tick = run & (st_reg.cnt == TIMER_DIVIDE - 2'h1);
endmodule : timer_prescale

/* File: include/tmr_pkg.sv */
// constants and types shared by the capture/reload timer design
package tmr_pkg;
   // register word indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_RELOAD_LOW = 8'hca;
   localparam logic [7:0] IDX_RELOAD_HIGH = 8'hcb;
   localparam logic [7:0] IDX_COUNT_LOW = 8'hcc;
   localparam logic [7:0] IDX_COUNT_HIGH = 8'hcd;
   localparam logic [7:0] IDX_CONTROL = 8'hc8;
   // control register field positions
   localparam int BIT_OVERFLOW = 7;
   localparam int BIT_TRIGGER_EVENT = 6;
   localparam int BIT_RX_BAUD = 5;
   localparam int BIT_TX_BAUD = 4;
   localparam int BIT_TRIGGER_ENABLE = 3;
   localparam int BIT_RUN = 2;
   localparam int BIT_COUNT_SOURCE = 1;
   localparam int BIT_CAPTURE_RELOAD = 0;
   // reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] RESET_CONTROL = 8'h00;
   // timer mode prescale: one count per this many system clocks
   localparam logic [1:0] TIMER_DIVIDE = 2'h2;
   // state of the falling edge detector
   typedef struct packed {
      logic sync_a;
      logic sync_b;
      logic last;
   } edge_state_type;
endpackage : tmr_pkg

/* File: verification/tb_timer_capture_reload.sv */
// self-checking bench for the capture/reload timer
`timescale 1ns/1ns
module tb_timer_capture_reload;
   import tmr_pkg::*;
   logic clk, resetn, ce, psel, penable, pwrite, pready, pslverr, ovf, cpin, tpin, hit;
   logic [31:0] paddr, pwdata, prdata;
   logic [3:0] pstrb;
   logic [32:0] exp_q[$];
   logic [7:0] v, mode[4] = '{8'h04, 8'h05, 8'h15, 8'h25}, trig[4] = '{8'h0f, 8'h0e, 8'h07, 8'h1e};
   int mismatches, cmp_count, cyc, pulses, seed, n;
   longint tw, t0;
   timer_capture_reload u_dut (.CLK(clk), .RESETN(resetn), .CE(ce), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .COUNT_INPUT_PIN(cpin),
      .TRIGGER_INPUT_PIN(tpin), .OVERFLOW_PULSE(ovf));
   tmr_pin_model u_pins (.clk(clk), .count_pin(cpin), .trig_pin(tpin));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic conclude();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude
   task automatic check(input logic [32:0] got, input logic [32:0] want);
      cmp_count++;
      if (got !== want)
      begin
         mismatches++;
         $display("[FAIL] %0t got %h want %h", $time, got, want);
      end
   endtask : check
   // watcher: pulse count, hang limit, and read results against the oldest note
   always @(posedge clk)
   begin
      cyc++;
      if (ovf === 1'b1)
         pulses++;
      if (psel && penable && !pwrite && pready === 1'b1)
         check({pslverr, prdata}, exp_q.pop_front());
      // the hang limit ends the run last, so nothing runs after the verdict
      if (cyc > 20000)
      begin
         mismatches++;
         $display("[FAIL] %0t timeout", $time);
         conclude();
      end
   end
   // one apb transfer; an idle clock follows so requests never collide
   task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] d,
                       input logic [3:0] s);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {22'h0, idx, 2'b00};
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      tw = $time;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : xfer
   task automatic wr16(input logic [7:0] idx, input logic [15:0] d);
      xfer(idx, 1'b1, d[7:0], 4'hf);
      xfer(idx + 8'h1, 1'b1, d[15:8], 4'hf);
   endtask : wr16
   task automatic rd(input logic [7:0] idx, input logic [7:0] want);
      exp_q.push_back({25'h0, want});
      xfer(idx, 1'b0, 8'h0, 4'hf);
   endtask : rd
   task automatic rd16(input logic [7:0] idx, input logic [15:0] want);
      rd(idx, want[7:0]);
      rd(idx + 8'h1, want[15:8]);
   endtask : rd16
   initial
   begin
      seed = 74;
      {resetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      ce = 1'b1;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      rd(IDX_CONTROL, 8'h0);
      rd16(IDX_RELOAD_LOW, 16'h0);
      rd16(IDX_COUNT_LOW, 16'h0);
      exp_q.push_back({1'b1, 32'h0});
      xfer(8'hc9, 1'b0, 8'h0, 4'hf);
      // random bytes; a write with no strobe must leave them alone
      for (int i = 0; i < 4; i++)
      begin
         v = 8'($random(seed));
         xfer(IDX_RELOAD_LOW + i[7:0], 1'b1, v, 4'hf);
         xfer(IDX_RELOAD_LOW + i[7:0], 1'b1, ~v, 4'h0);
         rd(IDX_RELOAD_LOW + i[7:0], v);
      end
      // timer mode across reload, capture and both baud sources
      foreach (mode[i])
      begin
         wr16(IDX_RELOAD_LOW, 16'h1234);
         wr16(IDX_COUNT_LOW, 16'hfffe);
         pulses = 0;
         xfer(IDX_CONTROL, 1'b1, mode[i], 4'hf);
         t0 = tw;
         repeat (9) @(posedge clk);
         hit = mode[i][5:4] == 2'b00;
         rd(IDX_CONTROL, mode[i] | {hit, 7'h0});
         xfer(IDX_CONTROL, 1'b1, mode[i] & 8'hfb, 4'hf);
         n = int'((tw - t0) / 8);
         rd(IDX_CONTROL, mode[i] & 8'hfb);
         rd16(IDX_COUNT_LOW, ((hit && mode[i][0]) ? 16'h0 : 16'h1234) + n[15:0] - 16'h2);
         check({1'b0, pulses}, 33'h1);
      end
      // counter mode: three falls, fast and slow
      wr16(IDX_COUNT_LOW, 16'h0);
      xfer(IDX_CONTROL, 1'b1, 8'h06, 4'hf);
      u_pins.fall(1'b0, 1);
      u_pins.fall(1'b0, 3);
      u_pins.fall(1'b0, 1);
      repeat (8) @(posedge clk);
      // a fall while the clock enable is low never reaches the frozen synchroniser
      ce <= 1'b0;
      u_pins.fall(1'b0, 2);
      ce <= 1'b1;
      rd16(IDX_COUNT_LOW, 16'h3);
      // trigger falls: capture, reload, disabled, baud-blocked
      foreach (trig[i])
      begin
         wr16(IDX_RELOAD_LOW, 16'h0102);
         wr16(IDX_COUNT_LOW, 16'h5a5a);
         xfer(IDX_CONTROL, 1'b1, trig[i], 4'hf);
         u_pins.fall(1'b1, 2);
         repeat (8) @(posedge clk);
         hit = trig[i][3] && trig[i][5:4] == 2'b00;
         rd(IDX_CONTROL, trig[i] | {1'b0, hit, 6'h0});
         rd16(IDX_COUNT_LOW, (hit && !trig[i][0]) ? 16'h0102 : 16'h5a5a);
         rd16(IDX_RELOAD_LOW, (hit && trig[i][0]) ? 16'h5a5a : 16'h0102);
      end
      conclude();
   end
endmodule : tb_timer_capture_reload
bind timer_capture_reload tmr_asserts u_chk (.CLK(CLK), .RESETN(RESETN), .CE(CE), .PSEL(PSEL),
   .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .OVERFLOW_PULSE(OVERFLOW_PULSE));

/* File: verification/tmr_asserts.sv */
// concurrent checks on the timer register bus and overflow pulse
`timescale 1ns/1ns
module tmr_asserts
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic OVERFLOW_PULSE
);
   logic mapped;
   logic acc;
   // only the five byte registers answer without error
   assign mapped = PADDR inside {32'h320, 32'h328, 32'h32c, 32'h330, 32'h334};
   assign acc = PSEL && PENABLE;
   default clocking dc @(posedge CLK); endclocking
   default disable iff (!RESETN);
   a_ready_high: assert property (PREADY) else $error("pready low");
   a_err_in_access: assert property (PSLVERR |-> acc) else $error("error outside access");
   a_upper_zero: assert property (PRDATA[31:8] == 24'h0) else $error("upper data set");
   a_rdata_idle: assert property (!acc |-> PRDATA == 32'h0) else $error("stale read data");
   a_mapped_ok: assert property (PSEL && !PENABLE && CE && mapped ##1 acc |-> !PSLVERR)
      else $error("error on mapped address");
   a_unmapped_err: assert property (PSEL && !PENABLE && CE && !mapped ##1 acc |-> PSLVERR)
      else $error("no error on unmapped address");
   a_err_reads_zero: assert property (PSLVERR |-> PRDATA == 32'h0) else $error("error data");
   // a wrap takes at least two clocks, so pulses never touch
   a_pulse_single: assert property (OVERFLOW_PULSE |=> !OVERFLOW_PULSE)
      else $error("long overflow pulse");
endmodule : tmr_asserts

/* File: verification/tmr_pin_model.sv */
// behavioural driver of the count and trigger pins
`timescale 1ns/1ns
module tmr_pin_model
(
   input wire logic clk,
   output logic count_pin,
   output logic trig_pin
);
   // pins idle high, as the board pull-ups hold them between pulses
   initial
   begin
      count_pin = 1'b1;
      trig_pin = 1'b1;
   end
   // one low pulse of hold clocks; hold 1 is the fastest the synchroniser sees
   task automatic fall(input bit trig, input int hold);
      @(posedge clk);
      if (trig)
         trig_pin <= 1'b0;
      else
         count_pin <= 1'b0;
      repeat (hold) @(posedge clk);
      trig_pin <= 1'b1;
      count_pin <= 1'b1;
      repeat (hold) @(posedge clk);
   endtask : fall
endmodule : tmr_pin_model
